// [charge_port_pkg.sv]
package charge_port_pkg;

    // Charging modes selected by the three mode pins
    typedef enum logic [2:0] {
        LOW_CURRENT_DEDICATED_CHARGING,
        DEDICATED_CHARGING,
        STANDARD_PORT,
        CLIENT,
        LOW_CURRENT_STANDARD_PORT,
        CHARGING_DOWNSTREAM
    } mode_t;

    // Top-level sequencing: normal operation or output discharge
    typedef enum logic {CTL_RUN, CTL_DISCHARGE} ctl_state_t;

    // Dedicated-charging scheme presented on the data lines
    typedef enum logic [1:0] {SCHEME_DIVIDER, SCHEME_ONE_V_TWO, SCHEME_SHORTED} scheme_t;

    // Timebase
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CNT_W = 27;

    // Times in ms, cycle counts derived from them
    localparam int unsigned LOAD_ASSERT_MS = 210;
    localparam int unsigned LOAD_RELEASE_MS = 3000;
    localparam int unsigned DISCHARGE_MS = 50;
    localparam int unsigned ONE_V_TWO_MS = 100;
    localparam int unsigned LOAD_ASSERT_CYCLES = LOAD_ASSERT_MS * CYCLES_PER_MS;
    localparam int unsigned LOAD_RELEASE_CYCLES = LOAD_RELEASE_MS * CYCLES_PER_MS;
    localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_MS * CYCLES_PER_MS;
    localparam int unsigned ONE_V_TWO_CYCLES = ONE_V_TWO_MS * CYCLES_PER_MS;

    // Register port
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h0;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
    localparam logic [3:0] OFF_STATE = 4'h8;

    // Interrupt bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_THERMAL = 0;
    localparam int unsigned IRQ_FAULT = 1;
    localparam int unsigned IRQ_LOAD = 2;
    localparam int unsigned IRQ_MODE = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // State register fields
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_SWITCH = 3;
    localparam int unsigned ST_THERMAL = 4;
    localparam int unsigned ST_LOAD = 5;
    localparam int unsigned ST_DISCH = 6;
    localparam int unsigned ST_PRESENT_SDP = 7;

    // Number of pin inputs through the synchroniser
    localparam int unsigned SYNC_W = 12;

endpackage

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] pin_in, // Raw pins
    output logic [WIDTH-1:0] pin_out // Synchronised pins
);
    // Two flops per bit; only the second reads the first
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta <= 1'b0;
                    pin_out[i] <= 1'b0;
                end
                else if (ce)
                begin
                    meta <= pin_in[i];
                    pin_out[i] <= meta;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [dcp_auto_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module dcp_auto_seq #(
    parameter int unsigned ONE_V_TWO_CYCLES = charge_port_pkg::ONE_V_TWO_CYCLES
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic active, // Dedicated mode in force
    input wire logic attached, // Compliant sink seen
    input wire logic released, // Sink let go of data line
    output charge_port_pkg::scheme_t scheme // Scheme presented
);
    localparam logic [26:0] LAST = 27'(ONE_V_TWO_CYCLES - 1);
    logic [26:0] cnt;
    charge_port_pkg::scheme_t next_scheme;
    wire cnt_done = (cnt == LAST);

    // Divider first, brief 1.2 V on attach, then shorted until release
    always_comb
    begin
        next_scheme = scheme;
        if (!active)
            next_scheme = charge_port_pkg::SCHEME_DIVIDER;
        else
            unique case (scheme)
                charge_port_pkg::SCHEME_DIVIDER:
                    if (attached)
                        next_scheme = charge_port_pkg::SCHEME_ONE_V_TWO;
                charge_port_pkg::SCHEME_ONE_V_TWO:
                    if (cnt_done)
                        next_scheme = charge_port_pkg::SCHEME_SHORTED;
                charge_port_pkg::SCHEME_SHORTED:
                    if (released)
                        next_scheme = charge_port_pkg::SCHEME_DIVIDER;
                default:
                    next_scheme = charge_port_pkg::SCHEME_DIVIDER;
            endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scheme <= charge_port_pkg::SCHEME_DIVIDER;
            cnt <= '0;
        end
        else if (ce)
        begin
            scheme <= next_scheme;
            cnt <= (scheme == charge_port_pkg::SCHEME_ONE_V_TWO && !cnt_done) ? cnt + 27'h1 : '0;
        end
    end

    property p_dcp_start;
        @(posedge clk) disable iff (!rst_n)
        ce && active && scheme == charge_port_pkg::SCHEME_DIVIDER && attached
            |=> scheme == charge_port_pkg::SCHEME_ONE_V_TWO;
    endproperty
    a_dcp_start: assert property (p_dcp_start) else $error("1.2 V step not entered");
endmodule
`default_nettype wire

// [charge_port_mode_controller.sv]
// Overview of operation
// - Track mode pins continuously, no request needed.
// - Decode pins into six charging modes.
// - High limit in 001/111, none in client.
// - Client: switch off, data through, outputs off.
// - Mode 111: charging port, auto switch, high limit.
// - 000 to/from 001 without discharge.
// - 110 to/from 111 without discharge.
// - Low-current modes: no fault on overcurrent.
// - Limiting: first thermal threshold shuts switch.
// - Not limiting: only second threshold shuts switch.
// - Restart after cooling, cycle while fault persists.
// - Fault low throughout thermal shutdown, except in client mode.
// - Status asserts after 210 ms above threshold.
// - Status releases after 3 s below threshold.
// - Discharge: switch off, discharge, switch on.
`timescale 1ns/1ps
`default_nettype none
module charge_port_mode_controller #(
    parameter int unsigned LOAD_ASSERT_CYCLES = charge_port_pkg::LOAD_ASSERT_CYCLES,
    parameter int unsigned LOAD_RELEASE_CYCLES = charge_port_pkg::LOAD_RELEASE_CYCLES,
    parameter int unsigned DISCHARGE_CYCLES = charge_port_pkg::DISCHARGE_CYCLES,
    parameter int unsigned ONE_V_TWO_CYCLES = charge_port_pkg::ONE_V_TWO_CYCLES
) (
    input wire logic clk, // 40 MHz clock
    input wire logic rst_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic mode_select_bit1, // Mode pin, MSB
    input wire logic mode_select_bit2, // Mode pin
    input wire logic mode_select_bit3, // Mode pin, LSB
    input wire logic current_limiting, // Switch in current limit
    input wire logic thermal_threshold_limiting, // Die above first threshold
    input wire logic thermal_threshold_normal, // Die above second threshold
    input wire logic load_above, // Load above low limit + 40 mA
    input wire logic load_below, // Load below low limit - 10 mA
    input wire logic bc12_attached, // Compliant sink on data lines
    input wire logic data_released, // Sink released data line
    input wire logic phone_misclassified, // Phone took port as dedicated
    input wire logic phone_data_connected, // Phone made data connection
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic switch_on, // Power switch gate
    output logic high_current_limit_setting, // Apply high limit
    output logic low_current_limit_setting, // Apply low limit
    output logic status_n, // Load status, active low
    output logic fault_out, // Fault pin level when driven
    output logic fault_oe, // Fault pin pulled low
    output logic cs_enable, // Cable compensation sense on
    output logic data_switch_on, // Data line switch closed
    output logic discharge_on, // Output discharge resistor on
    output logic [1:0] dcp_scheme, // Dedicated scheme shown
    output logic present_sdp, // Charging port shown as standard
    output logic irq // Interrupt, level
);
    localparam logic [26:0] LOAD_ASSERT_LAST = 27'(LOAD_ASSERT_CYCLES - 1);
    localparam logic [26:0] LOAD_RELEASE_LAST = 27'(LOAD_RELEASE_CYCLES - 1);
    localparam logic [26:0] DISCH_LAST = 27'(DISCHARGE_CYCLES - 1);
    // Pins cross into the clock domain before any logic reads them
    logic [11:0] pins_s;
    pin_sync #(.WIDTH(charge_port_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in({mode_select_bit1, mode_select_bit2, mode_select_bit3,
                 current_limiting, thermal_threshold_limiting,
                 thermal_threshold_normal, load_above, load_below,
                 bc12_attached, data_released, phone_misclassified,
                 phone_data_connected}),
        .pin_out(pins_s)
    );
    wire [2:0] sel = pins_s[11:9];
    wire lim_s = pins_s[8];
    wire temp_lim_s = pins_s[7];
    wire temp_norm_s = pins_s[6];
    wire above_s = pins_s[5];
    wire below_s = pins_s[4];
    wire attach_s = pins_s[3];
    wire release_s = pins_s[2];
    wire misclass_s = pins_s[1];
    wire connected_s = pins_s[0];
    // State
    charge_port_pkg::mode_t mode_cur;
    charge_port_pkg::ctl_state_t ctl_state;
    logic [26:0] disch_cnt;
    logic [26:0] load_cnt;
    logic load_hold;
    logic thermal_off;
    logic misclass_d;
    logic disch_for_sdp;
    logic sdp_shown;
    logic fault_act_d;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    charge_port_pkg::scheme_t scheme;
    // Pin decode into the commanded mode
    charge_port_pkg::mode_t target;
    assign target = sel[2] ?
        (sel[1] ? (sel[0] ? charge_port_pkg::CHARGING_DOWNSTREAM
                          : charge_port_pkg::LOW_CURRENT_STANDARD_PORT)
                : charge_port_pkg::CLIENT) :
        (sel[1] ? charge_port_pkg::STANDARD_PORT
                : (sel[0] ? charge_port_pkg::DEDICATED_CHARGING
                          : charge_port_pkg::LOW_CURRENT_DEDICATED_CHARGING));
    // Per-mode attributes
    wire is_client = (mode_cur == charge_port_pkg::CLIENT);
    wire is_low_current_dedicated_charging = (mode_cur == charge_port_pkg::LOW_CURRENT_DEDICATED_CHARGING);
    wire is_dcp = (mode_cur == charge_port_pkg::DEDICATED_CHARGING);
    wire is_low_current_standard_port = (mode_cur == charge_port_pkg::LOW_CURRENT_STANDARD_PORT);
    wire is_cdp = (mode_cur == charge_port_pkg::CHARGING_DOWNSTREAM);
    wire use_high = is_dcp || is_cdp;
    wire use_low = !use_high && !is_client;
    wire status_en = is_dcp || is_cdp;
    wire fault_en = !is_client;
    wire no_oc_fault = is_low_current_dedicated_charging || is_low_current_standard_port;
    wire running = (ctl_state == charge_port_pkg::CTL_RUN);
    wire dcp_active = running && (is_low_current_dedicated_charging || is_dcp);
    // Discharge-free pairs of modes
    wire pair_dcp = (is_low_current_dedicated_charging || is_dcp) &&
        (target == charge_port_pkg::LOW_CURRENT_DEDICATED_CHARGING ||
         target == charge_port_pkg::DEDICATED_CHARGING);
    wire pair_cdp = (is_low_current_standard_port || is_cdp) &&
        (target == charge_port_pkg::LOW_CURRENT_STANDARD_PORT ||
         target == charge_port_pkg::CHARGING_DOWNSTREAM);
    wire quiet = pair_dcp || pair_cdp;
    wire mode_change = (target != mode_cur);
    wire misclass_rise = misclass_s && !misclass_d;
    wire disch_done = (disch_cnt == DISCH_LAST);
    // Mode sequencer: immediate switch or discharge first
    charge_port_pkg::ctl_state_t next_ctl;
    charge_port_pkg::mode_t next_mode;
    logic next_for_sdp;
    logic next_sdp_shown;
    always_comb
    begin
        next_ctl = ctl_state;
        next_mode = mode_cur;
        next_for_sdp = disch_for_sdp;
        next_sdp_shown = sdp_shown;
        unique case (ctl_state)
            charge_port_pkg::CTL_RUN:
            begin
                if (mode_change && quiet)
                begin
                    next_mode = target;
                    next_sdp_shown = 1'b0;
                end
                else if (mode_change)
                begin
                    next_ctl = charge_port_pkg::CTL_DISCHARGE;
                    next_for_sdp = 1'b0;
                end
                else if (is_cdp && !sdp_shown && misclass_rise)
                begin
                    next_ctl = charge_port_pkg::CTL_DISCHARGE;
                    next_for_sdp = 1'b1;
                end
                else if (sdp_shown && connected_s)
                    next_sdp_shown = 1'b0;
            end
            charge_port_pkg::CTL_DISCHARGE:
                if (disch_done)
                begin
                    next_ctl = charge_port_pkg::CTL_RUN;
                    next_mode = target;
                    next_sdp_shown = disch_for_sdp &&
                        (target == charge_port_pkg::CHARGING_DOWNSTREAM);
                end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_state <= charge_port_pkg::CTL_RUN;
            mode_cur <= charge_port_pkg::CLIENT;
            disch_for_sdp <= 1'b0;
            sdp_shown <= 1'b0;
            misclass_d <= 1'b0;
            disch_cnt <= '0;
        end
        else if (ce)
        begin
            ctl_state <= next_ctl;
            mode_cur <= next_mode;
            disch_for_sdp <= next_for_sdp;
            sdp_shown <= next_sdp_shown;
            misclass_d <= misclass_s;
            disch_cnt <= (!running && !disch_done) ? disch_cnt + 27'h1 : '0;
        end
    end
    // Thermal shutdown: threshold follows limiting; cleared only once both
    // comparators have fallen, which the analog hysteresis makes ~20 C cooler
    wire switch_path = running && !is_client;
    wire over_temp = lim_s ? temp_lim_s : temp_norm_s;
    wire cooled = !temp_lim_s && !temp_norm_s;
    wire next_thermal = (switch_path && over_temp) || (thermal_off && !cooled);
    // Fault: thermal outside client mode, overcurrent except in client and low-current modes
    wire oc_fault = lim_s && switch_path && !no_oc_fault;
    wire fault_act = fault_en && (thermal_off || oc_fault);
    // Load status: qualified above/below dwell times
    wire load_cond = load_hold ? below_s : above_s;
    wire load_last = load_hold ? (load_cnt == LOAD_RELEASE_LAST)
                               : (load_cnt == LOAD_ASSERT_LAST);
    wire next_load_hold = status_en && (load_cond && load_last ? !load_hold
                                                               : load_hold);
    wire [26:0] next_load_cnt = (status_en && load_cond && !load_last) ?
                                load_cnt + 27'h1 : '0;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thermal_off <= 1'b0;
            load_hold <= 1'b0;
            load_cnt <= '0;
            fault_act_d <= 1'b0;
        end
        else if (ce)
        begin
            thermal_off <= next_thermal;
            load_hold <= next_load_hold;
            load_cnt <= next_load_cnt;
            fault_act_d <= fault_act;
        end
    end
    dcp_auto_seq #(.ONE_V_TWO_CYCLES(ONE_V_TWO_CYCLES)) u_dcp (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .active(dcp_active),
        .attached(attach_s),
        .released(release_s),
        .scheme(scheme)
    );
    // Register decode; the set of a sticky bit wins over its clear
    wire next_switch_off = !switch_path || thermal_off;
    wire wr_status = reg_wr && (reg_addr == charge_port_pkg::OFF_IRQ_STATUS);
    wire wr_mask = reg_wr && (reg_addr == charge_port_pkg::OFF_IRQ_MASK);
    wire [3:0] events = {mode_change && running && (quiet || next_ctl != ctl_state),
                         next_load_hold != load_hold,
                         fault_act && !fault_act_d,
                         next_thermal && !thermal_off};
    wire [3:0] next_irq_status = (irq_status & ~(wr_status ? reg_wdata[3:0] : 4'h0)) | events;
    wire [7:0] state_word = {sdp_shown, !running, load_hold, thermal_off,
                             !next_switch_off, 3'(mode_cur)};
    wire [7:0] next_rdata =
        !reg_rd ? 8'h00 :
        (reg_addr == charge_port_pkg::OFF_IRQ_STATUS) ? {4'h0, irq_status} :
        (reg_addr == charge_port_pkg::OFF_IRQ_MASK) ? {4'h0, irq_mask} :
        (reg_addr == charge_port_pkg::OFF_STATE) ? state_word : 8'h00;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= '0;
            irq_mask <= charge_port_pkg::IRQ_MASK_RESET;
        end
        else if (ce)
        begin
            irq_status <= next_irq_status;
            irq_mask <= wr_mask ? reg_wdata[3:0] : irq_mask;
        end
    end
    // Outputs come straight from flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
            switch_on <= 1'b0;
            high_current_limit_setting <= 1'b0;
            low_current_limit_setting <= 1'b0;
            status_n <= 1'b1;
            fault_out <= 1'b0;
            fault_oe <= 1'b0;
            cs_enable <= 1'b0;
            data_switch_on <= 1'b0;
            discharge_on <= 1'b0;
            dcp_scheme <= '0;
            present_sdp <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            reg_rdata <= next_rdata;
            switch_on <= !next_switch_off;
            high_current_limit_setting <= use_high;
            low_current_limit_setting <= use_low;
            status_n <= !next_load_hold;
            fault_oe <= fault_act;
            cs_enable <= !is_client;
            data_switch_on <= running && !is_low_current_dedicated_charging && !is_dcp;
            discharge_on <= !running;
            dcp_scheme <= 2'(scheme);
            present_sdp <= sdp_shown;
            irq <= |(next_irq_status & irq_mask);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_client;
        ce && is_client |=> !switch_on && !cs_enable && !fault_oe && status_n
            && !high_current_limit_setting && !low_current_limit_setting;
    endproperty
    a_client: assert property (p_client) else $error("client mode outputs wrong");
    property p_high;
        ce && running && (is_dcp || is_cdp) |=> high_current_limit_setting
            && !low_current_limit_setting;
    endproperty
    a_high: assert property (p_high) else $error("high limit not applied");
    property p_std;
        ce && mode_cur == charge_port_pkg::STANDARD_PORT |=> low_current_limit_setting
            && status_n && cs_enable;
    endproperty
    a_std: assert property (p_std) else $error("standard port outputs wrong");
    property p_quiet;
        ce && running && mode_change && quiet |=> running && mode_cur == $past(target);
    endproperty
    a_quiet: assert property (p_quiet) else $error("paired change discharged");
    property p_disch;
        ce && running && mode_change && !quiet |=> !running ##1 !ce || discharge_on;
    endproperty
    a_disch: assert property (p_disch) else $error("discharge missing");
    property p_disch_out;
        ce && !running |=> discharge_on && !switch_on && !data_switch_on;
    endproperty
    a_disch_out: assert property (p_disch_out) else $error("discharge outputs wrong");
    property p_no_oc;
        ce && no_oc_fault && !thermal_off |=> !fault_oe;
    endproperty
    a_no_oc: assert property (p_no_oc) else $error("overcurrent fault in low mode");
    property p_therm_fault;
        ce && thermal_off && fault_en |=> fault_oe && !switch_on;
    endproperty
    a_therm_fault: assert property (p_therm_fault) else $error("fault not low");
    property p_otsd_lim;
        ce && switch_path && lim_s && temp_lim_s |=> thermal_off;
    endproperty
    a_otsd_lim: assert property (p_otsd_lim) else $error("first threshold ignored");
    property p_otsd_norm;
        ce && !lim_s && !temp_norm_s && !thermal_off |=> !thermal_off;
    endproperty
    a_otsd_norm: assert property (p_otsd_norm) else $error("early shutdown");
    property p_restart;
        ce && thermal_off && cooled |=> !thermal_off;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_load_on;
        ce && !load_hold && load_hold != next_load_hold |-> status_en && above_s
            && load_cnt == LOAD_ASSERT_LAST;
    endproperty
    a_load_on: assert property (p_load_on) else $error("status asserted early");
    property p_load_off;
        ce && load_hold && status_en && !next_load_hold |-> below_s
            && load_cnt == LOAD_RELEASE_LAST;
    endproperty
    a_load_off: assert property (p_load_off) else $error("status released early");
endmodule
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk, // Clock
    input wire logic [2:0] want, // Mode asked by bench
    input wire logic fault_oe, // Fault pin pulled low
    output logic [2:0] pins, // Mode pins, bit1 first
    output logic fault_pin_n // Fault wire level
);
    // Pins move just after an edge, as a controller would
    always_ff @(posedge clk)
    begin
        pins <= want;
    end
    // Open drain with board pull-up, never left floating
    assign fault_pin_n = !fault_oe;
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, cl = 0, tl = 0, tn = 0, lb = 0, pd = 0, wr_s = 0, rd_s = 0;
    logic sw, hi, lo, st_n, f_out, f_oe, cs, dsw, dis, irq, f_n;
    logic la = 0, lbf = 0, ba = 0, dr = 0, pm = 0, psdp;
    logic [1:0] sch;
    logic [2:0] want = 3'h4, pins;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, rdata, d;
    logic [15:0] lf = 16'hE206;
    logic [2:0] seq [11] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h6, 3'h7, 3'h6, 3'h5, 3'h2, 3'h4, 3'h1};
    int error_cnt = 0, tests_run = 0;
    // Short counts keep the run small
    charge_port_mode_controller #(.LOAD_ASSERT_CYCLES(20), .LOAD_RELEASE_CYCLES(30),
        .DISCHARGE_CYCLES(8), .ONE_V_TWO_CYCLES(6)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .mode_select_bit1(pins[2]), .mode_select_bit2(pins[1]), .mode_select_bit3(pins[0]),
        .current_limiting(cl), .thermal_threshold_limiting(tl), .thermal_threshold_normal(tn),
        .load_above(la), .load_below(lb), .bc12_attached(ba), .data_released(dr),
        .phone_misclassified(pm), .phone_data_connected(pd), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .switch_on(sw),
        .high_current_limit_setting(hi), .low_current_limit_setting(lo), .status_n(st_n),
        .fault_out(f_out), .fault_oe(f_oe), .cs_enable(cs), .data_switch_on(dsw),
        .discharge_on(dis), .dcp_scheme(sch), .present_sdp(psdp), .irq(irq));
    host_model host (.clk(clk), .want(want), .fault_oe(f_oe), .pins(pins), .fault_pin_n(f_n));
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] next_lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Random below level; lbf holds it high through the release dwell
    always_ff @(posedge clk)
    begin
        lf <= next_lf(lf);
        lb <= lf[0] | lbf;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    // Quiet pairs must never show the discharge resistor
    task automatic go(input logic [2:0] m);
        logic e, saw, c, h;
        saw = 1'b0;
        c = m[2:1] == 2'b10;
        h = m == 3'h1 || m == 3'h7;
        @(posedge clk);
        e = !(want[2:1] == m[2:1] && want[2] == want[1]);
        want <= m;
        repeat (24)
        begin
            @(posedge clk);
            #1 saw = saw | dis;
        end
        chk("discharge", {7'h0, e}, {7'h0, saw});
        chk("mode_outs", {1'b0, h, !h && !c, !c, !c, m[2:1] != 2'b00, 2'b11},
            {1'b0, hi, lo, sw, cs, dsw, st_n, f_n});
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(charge_port_pkg::OFF_IRQ_MASK, d);
        chk("mask", 8'h00, d);
        rd(4'hC, d);
        chk("unmapped", 8'h00, d);
        foreach (seq[i]) go(seq[i]);
        // Mode 001 now: scheme steps, then load dwell edges
        @(posedge clk);
        ba <= 1'b1;
        w(9);
        chk("scheme_12v", 8'h01, {6'h0, sch});
        w(1);
        chk("scheme_short", 8'h02, {6'h0, sch});
        @(posedge clk);
        ba <= 1'b0;
        dr <= 1'b1;
        la <= 1'b1;
        w(6);
        chk("scheme_div", 8'h00, {6'h0, sch});
        w(15);
        chk("status_early", 8'h01, {7'h0, st_n});
        w(1);
        chk("status_on", 8'h00, {7'h0, st_n});
        @(posedge clk);
        la <= 1'b0;
        lbf <= 1'b1;
        dr <= 1'b0;
        w(10);
        chk("status_hold", 8'h00, {7'h0, st_n});
        w(30);
        chk("status_off", 8'h01, {7'h0, st_n});
        wr(charge_port_pkg::OFF_IRQ_MASK, 8'h01);
        @(posedge clk);
        cl <= 1'b1;
        tl <= 1'b1;
        lbf <= 1'b0;
        w(8);
        chk("sw_hot", 8'h00, {7'h0, sw});
        chk("fault_pin", 8'h00, {6'h0, f_out, f_n});
        chk("irq", 8'h01, {7'h0, irq});
        @(posedge clk);
        cl <= 1'b0;
        tl <= 1'b0;
        w(8);
        chk("sw_cool", 8'h01, {7'h0, sw});
        wr(charge_port_pkg::OFF_IRQ_STATUS, 8'h01);
        w(2);
        chk("irq_clr", 8'h00, {7'h0, irq});
        @(posedge clk);
        tl <= 1'b1;
        w(8);
        chk("sw_first", 8'h01, {7'h0, sw});
        @(posedge clk);
        tn <= 1'b1;
        w(8);
        chk("sw_second", 8'h00, {7'h0, sw});
        @(posedge clk);
        tl <= 1'b0;
        tn <= 1'b0;
        go(3'h0);
        @(posedge clk);
        cl <= 1'b1;
        w(8);
        chk("fault_oc", 8'h01, {7'h0, f_n});
        @(posedge clk);
        cl <= 1'b0;
        go(3'h7);
        @(posedge clk);
        pm <= 1'b1;
        w(20);
        chk("sdp_shown", 8'h01, {7'h0, psdp});
        @(posedge clk);
        pd <= 1'b1;
        w(6);
        chk("sdp_back", 8'h00, {6'h0, psdp, dis});
        final_report;
    end
    // Hang guard
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule
`default_nettype wire
